// ---- hdl/wss_pkg.sv ----
package wss_pkg;

  // Timing in its own units, then cycle counts
  localparam int CLK_PERIOD_NS = 10;
  localparam int DEB_NS = 1000;
  localparam int DEB_CYC = (DEB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_MS = 1000;
  localparam int WAKE_CYC_DEF = WAKE_MS * 1000000 / CLK_PERIOD_NS;
  localparam int BOOT_CYC = DEB_CYC + 4;
  localparam int DEB_W = 8;
  localparam int BOOT_W = 8;
  localparam int WAKE_W = 27;

  // Register byte addresses
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_TXLIM = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h008;
  localparam logic [11:0] ADDR_TXPWR = 12'h00C;

  // Control field positions and resets
  localparam int CTRL_WAKE = 3;
  localparam logic [2:0] CTRL_RST = 3'h5;
  localparam logic [7:0] TXLIM_RST = 8'h10;
  localparam logic [7:0] TXPWR_DEF = 8'h17;

  // Input vector lanes; idle levels follow the pin pulls
  localparam int IN_CARD = 0;
  localparam int IN_KILL = 1;
  localparam int IN_PROX = 2;
  localparam logic [2:0] IN_RST = 3'h6;

  typedef struct packed {
    logic rf_cmd_en;
    logic active_low;
    logic hotplug_en;
  } wss_ctrl_s;

  typedef struct packed {
    logic wake_busy;
    logic power_limited;
    logic flight_mode;
    logic card_access;
    logic card_present;
    logic boot_done;
  } wss_status_s;

  typedef enum logic [1:0] {
    WSS_BOOT = 2'b00,
    WSS_RUN = 2'b01
  } wss_phase_e;

  typedef enum logic [1:0] {
    WSS_WAKE_IDLE = 2'b00,
    WSS_WAKE_LOW = 2'b01
  } wss_wake_e;

endpackage

// ---- hdl/wss_top.sv ----
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module wss_top
  import wss_pkg::*;
#(
  parameter int WAKE_CYC = WAKE_CYC_DEF
) (
  input wire logic clk,                     // 100 MHz clock
  input wire logic rst,                     // Async reset, high
  input wire logic psel,                    // APB select
  input wire logic penable,                 // APB access phase
  input wire logic pwrite,                  // APB write
  input wire logic [11:0] paddr,            // APB byte address
  input wire logic [31:0] pwdata,           // APB write data
  output logic [31:0] prdata,               // APB read data
  output logic pready,                      // APB ready
  output logic pslverr,                     // APB error
  input wire logic card_present_sense,      // Card switch pin
  input wire logic radio_kill_n,            // Host radio kill pin
  input wire logic proximity_detect_n,      // Body sensor pin
  input wire logic wake_event,              // Ring, message or data
  output logic rf_status_lamp_n,            // Lamp, low is lit
  output logic host_wake_n,                 // Host wake, low pulse
  output logic flight_mode,                 // Radio disabled
  output logic card_access_en,              // Card may be accessed
  output logic card_init_start,             // Start card init, pulse
  output logic [7:0] tx_power_max           // Applied power ceiling
);

  // Debounce counter step, shared by all three inputs
  function automatic logic [DEB_W-1:0] deb_step(
    input logic raw,
    input logic cur,
    input logic [DEB_W-1:0] cnt
  );
    if (raw == cur) begin
      deb_step = '0;
    end else begin
      deb_step = cnt + 1'b1;
    end
  endfunction

  logic [2:0] sync1;
  logic [2:0] sync2;
  logic [2:0] filt;
  logic [DEB_W-1:0] deb_cnt [3];
  wss_ctrl_s ctrl;
  logic [7:0] txlim;
  wss_phase_e phase;
  logic [BOOT_W-1:0] boot_cnt;
  wss_wake_e wake_st;
  logic [WAKE_W-1:0] wake_cnt;
  logic boot_done;
  logic card_present;
  logic next_access;
  logic power_limited;
  logic sw_wake;
  logic wr_en;
  logic rd_setup;
  logic addr_ok;
  wss_status_s status;

  // Two stage pin synchroniser, idle at pull levels
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1 <= IN_RST;
      sync2 <= IN_RST;
    end else begin
      sync1 <= {proximity_detect_n, radio_kill_n, card_present_sense};
      sync2 <= sync1;
    end
  end

  // Level changes only after a stable run; glitches die here
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      filt <= IN_RST;
      for (int i = 0; i < 3; i++) begin
        deb_cnt[i] <= '0;
      end
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (deb_cnt[i] == DEB_W'(DEB_CYC - 1)) begin
          filt[i] <= sync2[i];
          deb_cnt[i] <= '0;
        end else begin
          deb_cnt[i] <= deb_step(sync2[i], filt[i], deb_cnt[i]);
        end
      end
    end
  end

  // Startup phase waits for filtered inputs to settle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase <= WSS_BOOT;
      boot_cnt <= '0;
    end else begin
      case (phase)
        WSS_BOOT: begin
          if (boot_cnt == BOOT_W'(BOOT_CYC - 1)) begin
            phase <= WSS_RUN;
          end else begin
            boot_cnt <= boot_cnt + 1'b1;
          end
        end
        WSS_RUN: begin
          phase <= WSS_RUN;
        end
        default: begin
          phase <= WSS_BOOT;
        end
      endcase
    end
  end

  assign boot_done = (phase == WSS_RUN);

  // Polarity select on the debounced presence level
  assign card_present = filt[IN_CARD] ^ ctrl.active_low;

  // Startup read on the last boot cycle; detect off then keeps it
  always_comb begin
    if (!boot_done) begin
      next_access = (boot_cnt == BOOT_W'(BOOT_CYC - 1)) &
                    (card_present | ~ctrl.hotplug_en);
    end else if (ctrl.hotplug_en) begin
      next_access = card_present;
    end else begin
      next_access = card_access_en;
    end
  end

  // Card access level and its init pulse on each opening
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      card_access_en <= 1'b0;
      card_init_start <= 1'b0;
    end else begin
      card_access_en <= next_access;
      card_init_start <= next_access & ~card_access_en;
    end
  end

  // Radio kill pin or command disable both mean flight
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flight_mode <= 1'b1; // Radio off in reset, so lamp agrees
      rf_status_lamp_n <= 1'b1;
    end else begin
      flight_mode <= ~filt[IN_KILL] | ~ctrl.rf_cmd_en;
      rf_status_lamp_n <= ~filt[IN_KILL] | ~ctrl.rf_cmd_en;
    end
  end

  // Cap power near a body; never raise above the default
  assign power_limited = ~filt[IN_PROX];
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_power_max <= TXPWR_DEF;
    end else if (power_limited && (txlim < TXPWR_DEF)) begin
      tx_power_max <= txlim;
    end else begin
      tx_power_max <= TXPWR_DEF;
    end
  end

  // Wake pulse; requests during a pulse are absorbed
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wake_st <= WSS_WAKE_IDLE;
      wake_cnt <= '0;
      host_wake_n <= 1'b1;
    end else begin
      case (wake_st)
        WSS_WAKE_IDLE: begin
          if (wake_event || sw_wake) begin
            wake_st <= WSS_WAKE_LOW;
            wake_cnt <= '0;
            host_wake_n <= 1'b0;
          end
        end
        WSS_WAKE_LOW: begin
          if (wake_cnt == WAKE_W'(WAKE_CYC - 1)) begin
            wake_st <= WSS_WAKE_IDLE;
            host_wake_n <= 1'b1;
          end else begin
            wake_cnt <= wake_cnt + 1'b1;
          end
        end
        default: begin
          wake_st <= WSS_WAKE_IDLE;
          host_wake_n <= 1'b1;
        end
      endcase
    end
  end

  // APB decode; zero wait states
  assign pready = 1'b1;
  assign addr_ok = (paddr == ADDR_CTRL) || (paddr == ADDR_TXLIM) ||
                   (paddr == ADDR_STATUS) || (paddr == ADDR_TXPWR);
  assign pslverr = psel & penable & ~addr_ok;
  assign wr_en = psel & penable & pwrite & addr_ok;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign sw_wake = wr_en && (paddr == ADDR_CTRL) && pwdata[CTRL_WAKE];

  // Software settings
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl <= CTRL_RST;
      txlim <= TXLIM_RST;
    end else if (wr_en) begin
      if (paddr == ADDR_CTRL) begin
        ctrl <= pwdata[2:0];
      end
      if (paddr == ADDR_TXLIM) begin
        txlim <= pwdata[7:0];
      end
    end
  end

  // Live state visible to software
  assign status.wake_busy = (wake_st == WSS_WAKE_LOW);
  assign status.power_limited = power_limited;
  assign status.flight_mode = flight_mode;
  assign status.card_present = card_present;
  assign status.boot_done = boot_done;
  assign status.card_access = card_access_en;

  // Read data captured in setup so it is stable in access
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata <= '0;
    end else if (rd_setup) begin
      case (paddr)
        ADDR_CTRL: prdata <= {29'h0, ctrl};
        ADDR_TXLIM: prdata <= {24'h0, txlim};
        ADDR_STATUS: prdata <= {26'h0, status};
        ADDR_TXPWR: prdata <= {24'h0, tx_power_max};
        default: prdata <= '0;
      endcase
    end
  end

  // Helper: length of each wake low pulse
  logic [31:0] low_len;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      low_len <= '0;
    end else if (!host_wake_n) begin
      low_len <= low_len + 1'b1;
    end else begin
      low_len <= '0;
    end
  end

  sequence s_wake_req;
    (wake_event || sw_wake) && host_wake_n;
  endsequence

  sequence s_wake_low;
    !host_wake_n [*2];
  endsequence

  a_wake_start: assert property (@(posedge clk) disable iff (rst)
    s_wake_req |=> s_wake_low)
    else $error("wake pulse did not start");

  a_wake_len: assert property (@(posedge clk) disable iff (rst)
    $rose(host_wake_n) |-> low_len == WAKE_CYC)
    else $error("wake pulse length wrong");

  a_kill_flight: assert property (@(posedge clk) disable iff (rst)
    !filt[IN_KILL] |=> flight_mode && rf_status_lamp_n)
    else $error("kill pin did not give flight");

  a_cmd_flight: assert property (@(posedge clk) disable iff (rst)
    $fell(ctrl.rf_cmd_en) |-> ##1 flight_mode ##0 rf_status_lamp_n)
    else $error("command disable did not give flight");

  a_lamp_on: assert property (@(posedge clk) disable iff (rst)
    filt[IN_KILL] && ctrl.rf_cmd_en |=> !rf_status_lamp_n)
    else $error("lamp not lit with RF on");

  a_lamp_flight: assert property (@(posedge clk) disable iff (rst)
    rf_status_lamp_n == flight_mode)
    else $error("lamp and flight disagree");

  a_filter_hold: assert property (@(posedge clk) disable iff (rst)
    filt != $past(filt) |-> $past(sync2) != $past(filt, 2))
    else $error("filter changed without a stable run");

  a_hp_insert: assert property (@(posedge clk) disable iff (rst)
    boot_done && ctrl.hotplug_en && card_present |=> card_access_en)
    else $error("present card not opened");

  a_hp_detach: assert property (@(posedge clk) disable iff (rst)
    ctrl.hotplug_en && !card_present |=> !card_access_en)
    else $error("absent card still open");

  a_hp_ignore: assert property (@(posedge clk) disable iff (rst)
    !ctrl.hotplug_en && card_access_en |=> card_access_en)
    else $error("card closed with detect off");

  a_init_pulse: assert property (@(posedge clk) disable iff (rst)
    $rose(card_access_en) |-> card_init_start ##1 !card_init_start)
    else $error("init pulse missing");

  a_polarity: assert property (@(posedge clk) disable iff (rst)
    ctrl.active_low |-> card_present == !filt[IN_CARD])
    else $error("presence polarity wrong");

  a_reset_cfg: assert property (@(posedge clk)
    $fell(rst) |-> ctrl.hotplug_en && !ctrl.active_low)
    else $error("reset settings wrong");

  a_prox_cap: assert property (@(posedge clk) disable iff (rst)
    !filt[IN_PROX] |=> tx_power_max <= txlim || tx_power_max == TXPWR_DEF)
    else $error("power not capped");

  a_prox_free: assert property (@(posedge clk) disable iff (rst)
    filt[IN_PROX] |=> tx_power_max == TXPWR_DEF)
    else $error("power capped without proximity");

  a_txlim_use: assert property (@(posedge clk) disable iff (rst)
    !filt[IN_PROX] && txlim < TXPWR_DEF ##1 $stable(txlim)
      |-> tx_power_max == $past(txlim))
    else $error("threshold not applied");

endmodule
`default_nettype wire

// ---- test/wss_far_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module wss_far_model
  import wss_pkg::*;
(
  input wire logic clk, // Bench clock
  input wire logic rst, // Async reset
  input wire logic card_in, // Card seated in slot
  input wire logic kill_in, // Host wants radio off
  input wire logic near_in, // Body close to antenna
  input wire logic host_wake_n, // Wake line from block
  input wire logic card_init_start, // Card init pulse
  output logic card_present_sense, // Slot switch pin
  output logic radio_kill_n, // Host kill pin
  output logic proximity_detect_n, // Sensor pin
  output logic [31:0] wake_len, // Last low pulse width
  output logic [7:0] init_cnt // Card init pulses seen
);
  logic [31:0] low_cnt;
  logic wake_q;
  // Pins are driven solid; pulled idle levels are high for kill and proximity, low for the card switch
  assign card_present_sense = card_in;
  assign radio_kill_n = ~kill_in;
  assign proximity_detect_n = ~near_in;
  // Host side measures each wake pulse it receives
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      low_cnt <= 32'h0;
      wake_q <= 1'b1;
      wake_len <= 32'h0;
      init_cnt <= 8'h0;
    end else begin
      wake_q <= host_wake_n;
      if (!host_wake_n) begin
        low_cnt <= low_cnt + 32'h1;
      end
      if (host_wake_n && !wake_q) begin
        wake_len <= low_cnt;
        low_cnt <= 32'h0;
      end
      if (card_init_start) begin
        init_cnt <= init_cnt + 8'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- test/wss_top_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module wss_top_tb
  import wss_pkg::*;
;
  localparam int WK = 20;
  localparam int SETTLE = DEB_CYC + 10;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, wake_event;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, wake_len;
  logic card_in, kill_in, near_in, card_present_sense, radio_kill_n;
  logic proximity_detect_n, rf_status_lamp_n, host_wake_n, flight_mode;
  logic card_access_en, card_init_start, slverr;
  logic [7:0] tx_power_max, init_cnt;
  int errors, cmp_count, n;
  wss_top #(.WAKE_CYC(WK)) wss_top_i (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .card_present_sense(card_present_sense), .radio_kill_n(radio_kill_n),
    .proximity_detect_n(proximity_detect_n), .wake_event(wake_event),
    .rf_status_lamp_n(rf_status_lamp_n), .host_wake_n(host_wake_n),
    .flight_mode(flight_mode), .card_access_en(card_access_en),
    .card_init_start(card_init_start), .tx_power_max(tx_power_max));
  wss_far_model wss_far_model_i (.clk(clk), .rst(rst), .card_in(card_in),
    .kill_in(kill_in), .near_in(near_in), .host_wake_n(host_wake_n),
    .card_init_start(card_init_start),
    .card_present_sense(card_present_sense), .radio_kill_n(radio_kill_n),
    .proximity_detect_n(proximity_detect_n), .wake_len(wake_len),
    .init_cnt(init_cnt));
  // Free-running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task finish_test();
    if (errors == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  // One APB transfer; request held until pready is seen high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    slverr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 50) begin
      errors++;
      finish_test();
    end
  endtask
  task step(input int c);
    repeat (c) @(posedge clk);
  endtask
  // Waits for the wake line to return high, bounded
  task wake_done();
    n = 0;
    while (host_wake_n !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    if (n >= 200) begin
      errors++;
      finish_test();
    end
    step(2);
  endtask
  // Main sequence; wake is requested by pin and by register
  initial begin
    {rst, psel, penable, pwrite, wake_event, kill_in, near_in} = 7'h40;
    paddr = 12'h000;
    pwdata = 32'h0;
    card_in = 1'b1;
    errors = 0;
    cmp_count = 0;
    step(3);
    rst <= 1'b0;
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk("ctrl", {29'h0, CTRL_RST}, rd);
    apb(1'b0, ADDR_TXLIM, 32'h0);
    chk("txlim", {24'h0, TXLIM_RST}, rd);
    apb(1'b0, 12'h010, 32'h0);
    chk("slverr", 32'h1, {31'h0, slverr});
    step(SETTLE);
    chk("access", 32'h1, {31'h0, card_access_en});
    chk("init", 32'h1, {24'h0, init_cnt});
    chk("lamp on", 32'h0, {31'h0, rf_status_lamp_n});
    chk("wake idle", 32'h1, {31'h0, host_wake_n});
    card_in <= 1'b0;
    step(SETTLE);
    chk("detach", 32'h0, {31'h0, card_access_en});
    card_in <= 1'b1;
    step(DEB_CYC / 2);
    chk("glitch mid", 32'h0, {31'h0, card_access_en});
    card_in <= 1'b0;
    step(SETTLE);
    chk("glitch", 32'h0, {31'h0, card_access_en});
    apb(1'b1, ADDR_CTRL, 32'h7);
    step(10);
    chk("low pol", 32'h1, {31'h0, card_access_en});
    // Card reads absent now; only ignoring the pin keeps access open
    apb(1'b1, ADDR_CTRL, 32'h4);
    card_in <= 1'b0;
    step(SETTLE);
    chk("no detect", 32'h1, {31'h0, card_access_en});
    apb(1'b1, ADDR_CTRL, 32'h5);
    kill_in <= 1'b1;
    step(SETTLE);
    chk("kill", 32'h1, {31'h0, flight_mode});
    chk("kill lamp", 32'h1, {31'h0, rf_status_lamp_n});
    kill_in <= 1'b0;
    step(SETTLE);
    chk("unkill", 32'h0, {31'h0, flight_mode});
    apb(1'b1, ADDR_CTRL, 32'h1);
    step(5);
    chk("cmd off", 32'h1, {31'h0, flight_mode});
    chk("cmd lamp", 32'h1, {31'h0, rf_status_lamp_n});
    apb(1'b1, ADDR_CTRL, 32'h5);
    step(5);
    chk("cmd on", 32'h0, {31'h0, rf_status_lamp_n});
    apb(1'b1, ADDR_TXLIM, 32'hC);
    near_in <= 1'b1;
    step(SETTLE);
    chk("cap", 32'hC, {24'h0, tx_power_max});
    apb(1'b0, ADDR_TXPWR, 32'h0);
    chk("txpwr", 32'hC, rd);
    near_in <= 1'b0;
    step(SETTLE);
    chk("uncap", {24'h0, TXPWR_DEF}, {24'h0, tx_power_max});
    wake_event <= 1'b1;
    step(1);
    wake_event <= 1'b0;
    step(5);
    wake_event <= 1'b1;
    step(1);
    wake_event <= 1'b0;
    wake_done();
    chk("wake len", WK, wake_len);
    apb(1'b1, ADDR_CTRL, 32'hD);
    step(3);
    chk("reg wake", 32'h0, {31'h0, host_wake_n});
    wake_done();
    chk("reg len", WK, wake_len);
    finish_test();
  end
endmodule
`default_nettype wire
